// [design/sacp_converter.sv]
// Overview of operation
// RULE1 - Start on falling start edge, ignoring select
// RULE2 - Idle: done high, sample-hold tracking
// RULE3 - Converting: hold engaged, done low
// RULE4 - Track again over 2 us before end
// RULE5 - Host may switch channel when done falls
// RULE6 - Done rises at completion; result valid
// RULE7 - Select and enable low drive result
// RULE8 - Host holds start low minimum width
// RULE9 - Host never holds start low continuously
// RULE10 - Done driven only while its enable low
// RULE11 - Result driven only when both strobes low
// RULE12 - Host lowers select before enable, setup
// RULE13 - Whole 14-bit result in one read
// RULE14 - Unipolar mode gives straight binary
// RULE15 - Bipolar mode gives twos complement
// RULE16 - Unipolar zero, midscale, full scale codes
// RULE17 - Bipolar max 01 1111..., wraps below midscale
// RULE18 - Host waits 10 us after power-up
// RULE19 - Host waits recovery after read before start
// Converter end: conversion sequencing, coding and three-state pins.
// Assumes the sample value arrives as an unsigned offset-binary code.
`timescale 1ns/1ps
module sacp_converter #(
    parameter int WIDTH = sacp_pkg::RESULT_WIDTH,
    parameter int CONVERT_CYCLES = sacp_pkg::CONVERT_CYCLES,
    parameter int TRACK_LEAD_CYCLES = sacp_pkg::TRACK_LEAD_CYCLES
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Pins
    sacp_link_if.converter link,
    // Analog side
    input wire logic [WIDTH-1:0] sampleCode,
    input wire logic bipolarOffsetPin,
    output logic trackMode,
    output logic sampleStrobe
);
    typedef enum logic [1:0] {
        IDLE = 2'b01,
        CONVERT = 2'b10
    } sacp_conv_state_type;

    typedef struct packed {
        sacp_conv_state_type phase;
        logic startPrev;
        logic [sacp_pkg::COUNT_WIDTH-1:0] count;
        logic [WIDTH-1:0] outputReg;
        logic [WIDTH-1:0] heldCode;
        logic bipolarMode;
        logic track;
        logic strobe;
    } sacp_conv_type;

    sacp_conv_type state, next_state;
    logic startFall;
    logic [WIDTH-1:0] coded;

    assign startFall = state.startPrev && !link.startConvert_n; // RULE1
    // Flip the top bit for twos complement
    assign coded = state.bipolarMode
        ? (state.heldCode ^ sacp_pkg::MIDSCALE_FLIP) // RULE15 RULE17
        : state.heldCode; // RULE14 RULE16

    always_comb begin
        next_state = state;
        next_state.startPrev = link.startConvert_n;
        next_state.strobe = 1'b0;
        unique case (state.phase)
            IDLE: begin
                next_state.track = 1'b1; // RULE2
                // Select is deliberately not looked at here
                if (startFall) begin // RULE1
                    next_state.phase = CONVERT;
                    next_state.track = 1'b0; // RULE3
                    next_state.strobe = 1'b1;
                    next_state.heldCode = sampleCode;
                    next_state.bipolarMode = bipolarOffsetPin;
                    next_state.count = sacp_pkg::ZERO_COUNT;
                end
            end
            CONVERT: begin
                next_state.count = state.count + 1'b1;
                if (state.count == sacp_pkg::COUNT_WIDTH'(CONVERT_CYCLES
                        - TRACK_LEAD_CYCLES - 1)) begin
                    next_state.track = 1'b1; // RULE4
                end
                if (state.count == sacp_pkg::COUNT_WIDTH'(CONVERT_CYCLES
                        - 1)) begin
                    next_state.phase = IDLE; // RULE6
                    next_state.outputReg = coded; // RULE13
                end
            end
            default: next_state.phase = IDLE;
        endcase
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            state.phase <= IDLE;
            state.startPrev <= 1'b1;
            state.count <= sacp_pkg::ZERO_COUNT;
            state.outputReg <= sacp_pkg::ZERO_RESULT;
            state.heldCode <= sacp_pkg::ZERO_RESULT;
            state.bipolarMode <= 1'b0;
            state.track <= 1'b1;
            state.strobe <= 1'b0;
        end else begin
            state <= next_state;
        end
    end

    assign trackMode = state.track;
    assign sampleStrobe = state.strobe;
    assign link.doneOut = (state.phase == IDLE); // RULE2 RULE3 RULE6
    assign link.doneOe = !link.doneFlagEnable_n; // RULE10
    assign link.resultOut = state.outputReg; // RULE7
    assign link.resultOe = !link.chipSelect_n
        && !link.outputEnable_n; // RULE11
endmodule // sacp_converter

// [design/sacp_host.sv]
// Host end: pulses start, polls done, reads the result in one access.
// Results pass a two-entry buffer so a stalled consumer loses none.
`timescale 1ns/1ps
module sacp_host #(
    parameter int WIDTH = sacp_pkg::RESULT_WIDTH,
    parameter int POWERUP_CYCLES = sacp_pkg::POWERUP_CYCLES
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Pins
    sacp_link_if.host link,
    // User request
    input wire logic startRequest,
    output logic busy,
    // User result stream
    output logic resultValid,
    input wire logic resultReady,
    output logic [WIDTH-1:0] resultData
);
    typedef enum logic [6:0] {
        POWERUP = 7'b0000001,
        IDLE = 7'b0000010,
        PULSE = 7'b0000100,
        WAITDONE = 7'b0001000,
        SELECT = 7'b0010000,
        READ = 7'b0100000,
        RECOVER = 7'b1000000
    } sacp_host_state_type;

    typedef struct packed {
        sacp_host_state_type phase;
        logic [sacp_pkg::COUNT_WIDTH-1:0] count;
        logic start_n;
        logic select_n;
        logic enable_n;
        logic push;
        logic doneEnable_n;
        logic [WIDTH-1:0] word;
    } sacp_host_type;

    sacp_host_type state, next_state;
    logic bufReady;

    sacp_skid_buffer #(.WIDTH(WIDTH), .DEPTH(2)) resultBuffer (
        .clock(clock),
        .rst(rst),
        .inValid(state.push),
        .inReady(bufReady),
        .inData(state.word),
        .outValid(resultValid),
        .outReady(resultReady),
        .outData(resultData)
    );

    always_comb begin
        next_state = state;
        next_state.push = 1'b0;
        next_state.count = state.count + 1'b1;
        unique case (state.phase)
            POWERUP: begin
                if (state.count == sacp_pkg::COUNT_WIDTH'(POWERUP_CYCLES
                        - 1)) begin // RULE18
                    next_state.phase = IDLE;
                end
            end
            IDLE: begin
                // Only start when a buffer slot is free for the result
                if (startRequest && bufReady) begin
                    next_state.phase = PULSE;
                    next_state.start_n = 1'b0;
                    next_state.count = sacp_pkg::ZERO_COUNT;
                end
            end
            PULSE: begin
                if (state.count == sacp_pkg::COUNT_WIDTH'(
                        sacp_pkg::START_PULSE_CYCLES - 1)) begin // RULE8
                    next_state.start_n = 1'b1; // RULE9
                    // Done pin enabled only while polled, so it can be shared
                    next_state.doneEnable_n = 1'b0;
                    next_state.phase = WAITDONE;
                end
            end
            WAITDONE: begin
                // Done is sampled only after the pulse, when low has begun
                if (link.doneFlag) begin
                    next_state.doneEnable_n = 1'b1;
                    next_state.phase = SELECT;
                    next_state.select_n = 1'b0;
                    next_state.count = sacp_pkg::ZERO_COUNT;
                end
            end
            SELECT: begin
                if (state.count == sacp_pkg::COUNT_WIDTH'(
                        sacp_pkg::SETUP_CYCLES - 1)) begin // RULE12
                    next_state.enable_n = 1'b0;
                    next_state.phase = READ;
                end
            end
            READ: begin
                next_state.word = link.resultBits; // RULE13
                next_state.push = 1'b1;
                next_state.enable_n = 1'b1;
                next_state.select_n = 1'b1;
                next_state.count = sacp_pkg::ZERO_COUNT;
                next_state.phase = RECOVER;
            end
            RECOVER: begin
                if (state.count == sacp_pkg::COUNT_WIDTH'(
                        sacp_pkg::RECOVERY_CYCLES - 1)) begin // RULE19
                    next_state.phase = IDLE;
                end
            end
            default: next_state.phase = IDLE;
        endcase
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            state.phase <= POWERUP;
            state.count <= sacp_pkg::ZERO_COUNT;
            state.start_n <= 1'b1;
            state.select_n <= 1'b1;
            state.enable_n <= 1'b1;
            state.push <= 1'b0;
            state.doneEnable_n <= 1'b1;
            state.word <= sacp_pkg::ZERO_RESULT;
        end else begin
            state <= next_state;
        end
    end

    assign link.startConvert_n = state.start_n;
    assign link.chipSelect_n = state.select_n;
    assign link.outputEnable_n = state.enable_n;
    assign link.doneFlagEnable_n = state.doneEnable_n;
    assign busy = (state.phase != IDLE);
endmodule // sacp_host

// [design/sacp_link_if.sv]
// Pin-level link between the converter end and the host end.
// Three-state pins are resolved here from the converter end's enables.
`timescale 1ns/1ps
interface sacp_link_if #(parameter int WIDTH = sacp_pkg::RESULT_WIDTH);
    logic startConvert_n;
    logic chipSelect_n;
    logic outputEnable_n;
    logic doneFlagEnable_n;
    logic doneOut;
    logic doneOe;
    logic [WIDTH-1:0] resultOut;
    logic resultOe;
    // Undriven lines read high, as with a pull-up
    wire doneFlag = doneOe ? doneOut : 1'b1;
    wire [WIDTH-1:0] resultBits = resultOe ? resultOut : {WIDTH{1'b1}};
    modport converter (
        input startConvert_n, chipSelect_n, outputEnable_n, doneFlagEnable_n,
        output doneOut, doneOe, resultOut, resultOe
    );
    modport host (
        output startConvert_n, chipSelect_n, outputEnable_n, doneFlagEnable_n,
        input doneFlag, resultBits
    );
endinterface

// [design/sacp_pkg.sv]
// Shared constants for the sampling converter conversion port.
// Assumes a 40 MHz single clock on both ends of the link.
package sacp_pkg;
    localparam int CLOCK_MHZ = 40;
    localparam int RESULT_WIDTH = 14;
    // Times in ns unless noted
    localparam int CONVERT_TIME_NS = 7800;
    localparam int TRACK_LEAD_NS = 2000;
    localparam int POWERUP_US = 10;
    localparam int START_PULSE_WIDTH_NS = 100;
    localparam int SELECT_TO_ENABLE_SETUP_NS = 50;
    localparam int READ_TO_START_RECOVERY_NS = 150;
    localparam int CONVERT_CYCLES = (CONVERT_TIME_NS * CLOCK_MHZ) / 1000;
    // Track returns this many cycles before the end of conversion
    localparam int TRACK_LEAD_CYCLES = (TRACK_LEAD_NS * CLOCK_MHZ + 999) / 1000;
    localparam int POWERUP_CYCLES = POWERUP_US * CLOCK_MHZ;
    localparam int START_PULSE_CYCLES =
        (START_PULSE_WIDTH_NS * CLOCK_MHZ + 999) / 1000;
    localparam int SETUP_CYCLES =
        (SELECT_TO_ENABLE_SETUP_NS * CLOCK_MHZ + 999) / 1000;
    localparam int RECOVERY_CYCLES =
        (READ_TO_START_RECOVERY_NS * CLOCK_MHZ + 999) / 1000;
    localparam int COUNT_WIDTH = 16;
    localparam logic [RESULT_WIDTH-1:0] MIDSCALE_FLIP = 14'h2000;
    localparam logic [RESULT_WIDTH-1:0] ZERO_RESULT = 14'h0000;
    localparam logic [COUNT_WIDTH-1:0] ZERO_COUNT = 16'h0000;
endpackage

// [design/sacp_skid_buffer.sv]
// Two-entry buffer with valid/ready on both sides.
// Assumes one clock and an active-high asynchronous reset.
`timescale 1ns/1ps
module sacp_skid_buffer #(
    parameter int WIDTH = sacp_pkg::RESULT_WIDTH,
    parameter int DEPTH = 2
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Fill side
    input wire logic inValid,
    output logic inReady,
    input wire logic [WIDTH-1:0] inData,
    // Drain side
    output logic outValid,
    input wire logic outReady,
    output logic [WIDTH-1:0] outData
);
    localparam int PW = $clog2(DEPTH);
    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [PW-1:0] rdPtr;
        logic [PW-1:0] wrPtr;
        logic [PW:0] count;
    } sacp_buf_type;
    sacp_buf_type state, next_state;
    logic push;
    logic pop;

    assign inReady = (state.count != (PW+1)'(DEPTH));
    assign outValid = (state.count != '0);
    assign outData = state.mem[state.rdPtr];
    assign push = inValid && inReady;
    assign pop = outValid && outReady;

    always_comb begin
        next_state = state;
        if (push) begin
            next_state.mem[state.wrPtr] = inData;
            next_state.wrPtr = (state.wrPtr == PW'(DEPTH - 1)) ? '0
                : state.wrPtr + 1'b1;
        end
        if (pop) begin
            next_state.rdPtr = (state.rdPtr == PW'(DEPTH - 1)) ? '0
                : state.rdPtr + 1'b1;
        end
        if (push && !pop) begin
            next_state.count = state.count + 1'b1;
        end else if (pop && !push) begin
            next_state.count = state.count - 1'b1;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end
endmodule // sacp_skid_buffer

// [verification/sacp_link_checker.sv]
// Concurrent checks on the pins between converter end and host end.
// Assumes one clock and an active-high asynchronous reset.
`timescale 1ns/1ps
module sacp_link_checker #(
    parameter int CONVERT_CYCLES = 312
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Host strobes
    input wire logic startConvert_n,
    input wire logic chipSelect_n,
    input wire logic outputEnable_n,
    input wire logic doneFlagEnable_n,
    // Converter drivers
    input wire logic doneOut,
    input wire logic doneOe,
    input wire logic [sacp_pkg::RESULT_WIDTH-1:0] resultOut,
    input wire logic resultOe,
    input wire logic doneFlag
);
    logic [15:0] lowCount;

    // Consecutive cycles with done low
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            lowCount <= 16'h0000;
        end else if (doneOut) begin
            lowCount <= 16'h0000;
        end else begin
            lowCount <= lowCount + 16'h0001;
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    AST_START_DONE: assert property ($fell(startConvert_n) && doneOut
        |-> ##[1:2] !doneOut) else $error("done did not fall after start");
    AST_IDLE_HOLD: assert property
        (doneOut && startConvert_n |=> doneOut)
        else $error("done fell without a start");
    AST_CONVERT_LEN: assert property ($rose(doneOut)
        |-> lowCount == CONVERT_CYCLES) else $error("wrong conversion length");
    AST_RESULT_UPDATE: assert property
        ($changed(resultOut) |-> $rose(doneOut))
        else $error("result changed outside completion");
    AST_DONE_DRIVE: assert property (doneOe == !doneFlagEnable_n
        && (!doneOe || doneFlag == doneOut)) else $error("done drive wrong");
    AST_RESULT_DRIVE: assert property
        (resultOe == (!chipSelect_n && !outputEnable_n))
        else $error("result drive wrong");
    AST_READ_SETUP: assert property ($fell(outputEnable_n)
        |-> !chipSelect_n && !$past(chipSelect_n, 2))
        else $error("select setup too short");
    AST_ONE_READ: assert property (!outputEnable_n |=> outputEnable_n)
        else $error("enable held over one cycle");
    AST_START_WIDTH: assert property ($fell(startConvert_n)
        |-> !startConvert_n [*4] ##1 startConvert_n)
        else $error("start pulse width wrong");
    AST_RECOVERY: assert property ($rose(outputEnable_n)
        |-> startConvert_n [*6]) else $error("start too soon after read");
endmodule // sacp_link_checker

// [verification/testbench.sv]
// Top bench: host and converter ends joined by the link interface.
// Assumes shortened power-up and conversion counts.
`timescale 1ns/1ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin errors++; \
    $display("FAIL %0t got %h want %h", $time, a, b); end end
module testbench;
    localparam int CONV = 100;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic [13:0] sampleCode = 14'h0000;
    logic bipolarOffsetPin = 1'b0;
    logic startRequest = 1'b0;
    logic resultReady = 1'b0;
    logic trackMode, sampleStrobe, busy, resultValid;
    logic [13:0] resultData;
    int errors = 0;
    int n_checks = 0;

    always #12.5 clock = ~clock;

    sacp_link_if link ();
    sacp_converter #(.CONVERT_CYCLES(CONV)) i_sacp_converter (.clock(clock),
        .rst(rst), .link(link), .sampleCode(sampleCode),
        .bipolarOffsetPin(bipolarOffsetPin), .trackMode(trackMode),
        .sampleStrobe(sampleStrobe));
    sacp_host #(.POWERUP_CYCLES(8)) i_sacp_host (.clock(clock), .rst(rst),
        .link(link), .startRequest(startRequest), .busy(busy),
        .resultValid(resultValid), .resultReady(resultReady),
        .resultData(resultData));
    sacp_link_checker #(.CONVERT_CYCLES(CONV)) i_sacp_link_checker (
        .clock(clock), .rst(rst), .startConvert_n(link.startConvert_n),
        .chipSelect_n(link.chipSelect_n), .outputEnable_n(link.outputEnable_n),
        .doneFlagEnable_n(link.doneFlagEnable_n), .doneOut(link.doneOut),
        .doneOe(link.doneOe), .resultOut(link.resultOut),
        .resultOe(link.resultOe), .doneFlag(link.doneFlag));

    // Starts one conversion and waits until the host is idle again
    task automatic start_conv(input logic [13:0] code, input logic bip);
        int n;
        int tr;
        int dn;
        n = 0;
        tr = 0;
        dn = 0;
        `CHK(trackMode, 1'b1)
        @(posedge clock);
        sampleCode <= code;
        bipolarOffsetPin <= bip;
        startRequest <= 1'b1;
        @(posedge clock);
        startRequest <= 1'b0;
        while ((busy !== 1'b0 || n < 8) && n < 2000) begin
            @(posedge clock);
            if (n == 4) begin
                sampleCode <= ~code;
                bipolarOffsetPin <= ~bip;
            end
            #1;
            n++;
            if (n == 1) begin
                `CHK({sampleStrobe, trackMode}, 2'b10)
            end
            if (n == 2) begin
                `CHK({link.doneFlag, link.doneOut}, 2'b10)
            end
            if (n == 5) begin
                `CHK({link.doneFlag, trackMode, sampleStrobe}, 3'b000)
                `CHK(link.resultBits, 14'h3fff)
            end
            if (n > 5 && trackMode === 1'b1 && tr == 0) tr = n;
            if (n > 5 && link.doneFlag === 1'b1 && dn == 0) dn = n;
        end
        `CHK(busy, 1'b0)
        `CHK(tr > 0 && dn - tr >= sacp_pkg::TRACK_LEAD_CYCLES, 1'b1)
    endtask

    task automatic take_word(input logic [13:0] expected);
        int n;
        n = 0;
        // Step past the pop edge so the buffer output has settled
        #1;
        while (resultValid !== 1'b1 && n < 2000) begin
            @(posedge clock);
            #1;
            n++;
        end
        `CHK(resultValid, 1'b1)
        `CHK(resultData, expected)
        @(posedge clock);
        resultReady <= 1'b1;
        @(posedge clock);
        resultReady <= 1'b0;
    endtask

    task automatic conv_read(input logic [13:0] code, input logic bip,
        input logic [13:0] expected);
        start_conv(code, bip);
        take_word(expected);
    endtask

    task automatic coding_table;
        conv_read(14'h0000, 1'b0, 14'h0000);
        conv_read(14'h2000, 1'b0, 14'h2000);
        conv_read(14'h3fff, 1'b0, 14'h3fff);
        conv_read(14'h3fff, 1'b1, 14'h1fff);
        conv_read(14'h1fff, 1'b1, 14'h3fff);
        conv_read(14'h2000, 1'b1, 14'h0000);
    endtask

    // Stalled consumer: two words wait, a third request is refused
    task automatic buffer_full;
        start_conv(14'h0123, 1'b0);
        start_conv(14'h0456, 1'b0);
        @(posedge clock);
        startRequest <= 1'b1;
        @(posedge clock);
        startRequest <= 1'b0;
        #1;
        `CHK(busy, 1'b0)
        take_word(14'h0123);
        take_word(14'h0456);
        #1;
        `CHK(resultValid, 1'b0)
    endtask

    task automatic complete_run;
        $display("Checks %0d, errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    initial begin
        repeat (3) @(posedge clock);
        rst <= 1'b0;
        repeat (2) @(posedge clock);
        #1;
        `CHK({busy, link.startConvert_n}, 2'b11)
        repeat (10) @(posedge clock);
        #1;
        `CHK(busy, 1'b0)
        coding_table();
        buffer_full();
        complete_run();
    end

    initial begin
        #(25 * 20000);
        errors++;
        complete_run();
    end
endmodule // testbench
